/* ebra_pkg.sv */
package ebra_pkg;
	// ==========================================
	// Cycle phases
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CMD_DELAY,
		ST_WAIT,
		ST_READY,
		ST_MUX,
		ST_TRI,
		ST_HOLD,
		ST_REGAIN
	} ebra_state_t;

	// ==========================================
	// Widths and reset values
	localparam int WAIT_W = 4;
	localparam logic [WAIT_W-1:0] WAIT_RST = 4'h0;
	localparam logic READY_ACT_LOW_RST = 1'b1;

	// ==========================================
	// Cycle request and programming
	typedef struct packed {
		logic start;
		logic write;
		logic cmd_delay;
		logic [WAIT_W-1:0] memory_cycle_wait_count;
		logic muxed;
		logic tristate_wait_state;
	} ebra_req_t;

	// Bus pin group towards the outside
	typedef struct packed {
		logic read_cmd_b;
		logic write_cmd_b;
		logic chip_select_oe;
		logic other_oe;
	} ebra_pins_t;
endpackage

/* ebra_wait_cnt.sv */
`timescale 1ns/1ps
module ebra_wait_cnt #(
	parameter int W = ebra_pkg::WAIT_W
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic load_i,
	input wire logic [W-1:0] value_i,
	output logic zero_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} ebra_cnt_t;

	ebra_cnt_t st_reg;
	ebra_cnt_t st_next;

	// Zero width leaves no room for a count
	if (W < 1) begin : g_width_chk
		$error("wait counter width too small");
	end

	always_comb begin
		st_next = st_reg;
		if (load_i) begin
			st_next.cnt = value_i;
		end else if (st_reg.cnt != '0) begin
			st_next.cnt = st_reg.cnt - 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg.cnt <= W'(ebra_pkg::WAIT_RST);
		end else begin
			st_reg <= st_next;
		end
	end

	assign zero_o = (st_reg.cnt == '0);
endmodule

/* ebra_bus_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// - READY inactive at sample adds a wait state; active ends the cycle; polarity selectable
// - Run programmed memory cycle wait states before sampling READY; zero allowed
// - Command leading edge follows the programmed command delay setting
// - Multiplexed cycles add a mux wait state plus optional tristate wait state
// - Next cycle starts only after post-cycle wait states elapse
// - HOLD sampled on the clock; acknowledge and request change on clock edges
// - Running cycle finishes before acknowledge is given
// - On release, chip selects and other bus signals float
// - Bus request may assert two clocks after acknowledge at the earliest
// - Regain starts only when HOLD goes inactive
// - After regain completes, the next own cycle may start
module ebra_bus_ctrl (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire ebra_pkg::ebra_req_t req_i,
	input wire logic ready_i,
	input wire logic ready_active_low_i,
	input wire logic hold_b_i,
	input wire logic want_bus_i,
	output logic busy_o,
	output logic cycle_done_o,
	output logic system_clock_output_o,
	output ebra_pkg::ebra_pins_t pins_o,
	output logic hold_acknowledge_out_b_o,
	output logic bus_request_out_b_o
);
	// ==========================================
	// State
	typedef struct packed {
		ebra_pkg::ebra_state_t state;
		logic write;
		logic muxed;
		logic tri_ws;
		logic busy;
		logic done;
		logic clk_out;
		ebra_pkg::ebra_pins_t pins;
		logic hold_ack_b;
		logic bus_req_b;
		logic hold_ack_seen;
	} ebra_st_t;

	ebra_st_t st_reg;
	ebra_st_t st_next;
	logic wait_zero;
	logic wait_load;
	logic ready_act;
	logic hold_act;

	// ==========================================
	// Input qualification
	// Polarity select
	assign ready_act = ready_active_low_i ? !ready_i : ready_i;
	assign hold_act = !hold_b_i;
	assign wait_load = (st_next.state == ebra_pkg::ST_WAIT) &&
		(st_reg.state != ebra_pkg::ST_WAIT);

	ebra_wait_cnt #(.W(ebra_pkg::WAIT_W)) u_wait (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.load_i(wait_load),
		.value_i(req_i.memory_cycle_wait_count),
		.zero_o(wait_zero)
	);

	// ==========================================
	// Sequencer
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		st_next.clk_out = !st_reg.clk_out;
		case (st_reg.state)
			ebra_pkg::ST_IDLE: begin
				st_next.busy = 1'b0;
				if (hold_act) begin
					st_next.state = ebra_pkg::ST_HOLD;
					st_next.hold_ack_b = 1'b0;
					st_next.pins.chip_select_oe = 1'b0;
					st_next.pins.other_oe = 1'b0;
					st_next.hold_ack_seen = 1'b0;
				end else if (req_i.start) begin
					st_next.busy = 1'b1;
					st_next.write = req_i.write;
					st_next.muxed = req_i.muxed;
					st_next.tri_ws = req_i.tristate_wait_state;
					if (req_i.cmd_delay) begin
						st_next.state = ebra_pkg::ST_CMD_DELAY;
					end else begin
						st_next.state = ebra_pkg::ST_WAIT;
						st_next.pins.read_cmd_b = req_i.write;
						st_next.pins.write_cmd_b = !req_i.write;
					end
				end
			end
			ebra_pkg::ST_CMD_DELAY: begin
				st_next.state = ebra_pkg::ST_WAIT;
				st_next.pins.read_cmd_b = st_reg.write;
				st_next.pins.write_cmd_b = !st_reg.write;
			end
			ebra_pkg::ST_WAIT: begin
				if (wait_zero) begin
					st_next.state = ebra_pkg::ST_READY;
				end
			end
			ebra_pkg::ST_READY: begin
				if (ready_act) begin
					st_next.pins.read_cmd_b = 1'b1;
					st_next.pins.write_cmd_b = 1'b1;
					st_next.done = 1'b1;
					if (st_reg.muxed) begin
						st_next.state = ebra_pkg::ST_MUX;
					end else if (st_reg.tri_ws) begin
						st_next.state = ebra_pkg::ST_TRI;
					end else begin
						st_next.state = ebra_pkg::ST_IDLE;
						st_next.busy = 1'b0;
					end
				end
			end
			ebra_pkg::ST_MUX: begin
				st_next.state = st_reg.tri_ws ? ebra_pkg::ST_TRI : ebra_pkg::ST_IDLE;
				st_next.busy = st_reg.tri_ws;
			end
			ebra_pkg::ST_TRI: begin
				st_next.state = ebra_pkg::ST_IDLE;
				st_next.busy = 1'b0;
			end
			ebra_pkg::ST_HOLD: begin
				// Stay floated while HOLD is active
				st_next.hold_ack_seen = 1'b1;
				st_next.bus_req_b = !(st_reg.hold_ack_seen && want_bus_i);
				if (!hold_act) begin
					st_next.state = ebra_pkg::ST_REGAIN;
					st_next.hold_ack_b = 1'b1;
				end
			end
			ebra_pkg::ST_REGAIN: begin
				st_next.bus_req_b = 1'b1;
				st_next.pins.chip_select_oe = 1'b1;
				st_next.pins.other_oe = 1'b1;
				st_next.state = ebra_pkg::ST_IDLE;
			end
			default: begin
				st_next.state = ebra_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg.state <= ebra_pkg::ST_IDLE;
			st_reg.write <= 1'b0;
			st_reg.muxed <= 1'b0;
			st_reg.tri_ws <= 1'b0;
			st_reg.busy <= 1'b0;
			st_reg.done <= 1'b0;
			st_reg.clk_out <= 1'b0;
			st_reg.pins <= 4'h3 | 4'hc;
			st_reg.hold_ack_b <= 1'b1;
			st_reg.bus_req_b <= 1'b1;
			st_reg.hold_ack_seen <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy_o = st_reg.busy;
	assign cycle_done_o = st_reg.done;
	assign system_clock_output_o = st_reg.clk_out;
	assign pins_o = st_reg.pins;
	assign hold_acknowledge_out_b_o = st_reg.hold_ack_b;
	assign bus_request_out_b_o = st_reg.bus_req_b;

	// ==========================================
	// Checks
	floated_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!st_reg.hold_ack_b |-> !st_reg.pins.chip_select_oe && !st_reg.pins.other_oe)
		else $error("bus driven while acknowledged");
	no_cycle_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		!st_reg.hold_ack_b |-> st_reg.pins.read_cmd_b && st_reg.pins.write_cmd_b)
		else $error("command during hold");
	hold_persist_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(!st_reg.hold_ack_b && hold_act) |=> !st_reg.hold_ack_b)
		else $error("acknowledge dropped while hold active");
	regain_on_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$rose(st_reg.hold_ack_b) |-> $past(!hold_b_i, 1) == 1'b0)
		else $error("regain without hold release");
	bus_req_late_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$fell(st_reg.bus_req_b) |-> $past(st_reg.hold_ack_b, 2) == 1'b0)
		else $error("bus request too early");
	ready_end_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(st_reg.state == ebra_pkg::ST_READY && ready_act) |=> st_reg.done)
		else $error("ready did not end cycle");
	ready_ext_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(st_reg.state == ebra_pkg::ST_READY && !ready_act) |=>
		st_reg.state == ebra_pkg::ST_READY)
		else $error("no wait state on inactive ready");
	mux_gap_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(st_reg.done && st_reg.muxed && st_reg.tri_ws) |-> st_reg.busy ##1 st_reg.busy)
		else $error("mux gap short");
	grant_idle_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$fell(st_reg.hold_ack_b) |-> $past(st_reg.state, 1) == ebra_pkg::ST_IDLE)
		else $error("grant during cycle");
	cmd_delay_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(st_reg.state == ebra_pkg::ST_CMD_DELAY) |->
		(st_reg.pins.read_cmd_b && st_reg.pins.write_cmd_b))
		else $error("command before delay elapsed");
	gap_quiet_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(st_reg.state == ebra_pkg::ST_MUX || st_reg.state == ebra_pkg::ST_TRI) |=>
		(st_reg.pins.read_cmd_b && st_reg.pins.write_cmd_b))
		else $error("cycle started inside gap");
endmodule

/* ebra_resp_model.sv */
`timescale 1ns/1ps
module ebra_resp_model (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic cmd_b_i,
	input wire logic act_low_i,
	input wire logic [3:0] lag_i,
	output logic ready_o
);
	logic [3:0] cnt_reg;
	// ==========================================
	// Slow or prompt responder
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= 4'h0;
		end else if (cmd_b_i) begin
			cnt_reg <= 4'h0;
		end else if (cnt_reg != 4'hf) begin
			cnt_reg <= cnt_reg + 4'h1;
		end
	end
	assign ready_o = act_low_i ^ (!cmd_b_i && cnt_reg >= lag_i);
endmodule

/* ext_bus_ready_hold_arbitration_tb_top.sv */
`timescale 1ns/1ps
module ext_bus_ready_hold_arbitration_tb_top;
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	ebra_pkg::ebra_req_t req = '0;
	logic act_low = 1'b1;
	logic hold_b = 1'b1;
	logic want = 1'b0;
	logic [3:0] lag = 4'h0;
	logic ready, busy, done, clk_out, ack_b, brq_b;
	ebra_pkg::ebra_pins_t pins;
	int n_errors = 0;
	int checks_done = 0;
	// ==========================================
	// Clock, design and responder
	initial begin
		forever #25 clock_i = ~clock_i;
	end
	ebra_bus_ctrl dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req), .ready_i(ready),
		.ready_active_low_i(act_low), .hold_b_i(hold_b), .want_bus_i(want), .busy_o(busy),
		.cycle_done_o(done), .system_clock_output_o(clk_out), .pins_o(pins),
		.hold_acknowledge_out_b_o(ack_b), .bus_request_out_b_o(brq_b));
	ebra_resp_model resp (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.cmd_b_i(pins.read_cmd_b & pins.write_cmd_b), .act_low_i(act_low), .lag_i(lag),
		.ready_o(ready));
	// ==========================================
	// Helpers
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Bounded wait; running out counts and ends the run
	task automatic wait_for(input logic want_done, input int lim, output int k);
		k = 0;
		while ((want_done ? done !== 1'b1 : ack_b !== 1'b0) && k < lim) begin
			@(posedge clock_i);
			#1;
			k++;
		end
		if (k >= lim) begin
			check("timeout", 8'h1, 8'h0);
			print_verdict();
		end
	endtask
	task automatic run_cycle(input logic wr, dl, mx, tr, input logic [3:0] n, lg);
		int k;
		int ex;
		@(posedge clock_i);
		lag <= lg;
		req <= '{1'b1, wr, dl, n, mx, tr};
		@(posedge clock_i);
		req.start <= 1'b0;
		// Just after the taking edge: command low at once, or still high with delay
		#1;
		check("cmd_edge", wr ? pins.write_cmd_b : pins.read_cmd_b, {7'h0, dl});
		wait_for(1'b1, 60, k);
		// At least one wait-count edge and one READY edge after the taking edge
		ex = 2 + dl + n + ((int'(lg) > int'(n) + 1) ? int'(lg) - int'(n) - 1 : 0);
		check("cycle_len", k[7:0], ex[7:0]);
		k = 0;
		while (busy === 1'b1 && k < 9) begin
			@(posedge clock_i);
			#1;
			k++;
		end
		check("gap", k[7:0], {6'h0, mx & tr, mx ^ tr});
	endtask
	// ==========================================
	// Scenarios
	task automatic t_ready();
		for (int p = 0; p < 2; p++) begin
			@(posedge clock_i);
			act_low <= p[0];
			run_cycle(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
			run_cycle(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h4);
		end
		$display("test ready polarity done");
	endtask
	task automatic t_waits();
		run_cycle(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0);
		run_cycle(1'b1, 1'b1, 1'b0, 1'b0, 4'h3, 4'h2);
		run_cycle(1'b0, 1'b0, 1'b0, 1'b0, 4'hf, 4'h0);
		$display("test wait states done");
	endtask
	task automatic t_gap();
		run_cycle(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 4'h0);
		run_cycle(1'b1, 1'b1, 1'b1, 1'b1, 4'h2, 4'h0);
		run_cycle(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
		$display("test cycle gap done");
	endtask
	// Start stays requested through the hold, so it must wait for the regain
	task automatic t_hold(input logic wb);
		int k;
		@(posedge clock_i);
		want <= wb;
		lag <= 4'h0;
		hold_b <= 1'b0;
		req.start <= 1'b1;
		wait_for(1'b0, 4, k);
		check("release", {busy, pins.chip_select_oe, pins.other_oe, brq_b}, 8'h1);
		repeat (8) @(posedge clock_i);
		#1;
		check("held", {ack_b, busy, pins.other_oe, brq_b}, {7'h0, ~wb});
		@(posedge clock_i);
		hold_b <= 1'b1;
		@(posedge clock_i);
		#1;
		// Acknowledge withdrawn on the sampling edge, bus not yet driven again
		check("ack_drop", {ack_b, pins.chip_select_oe}, 8'h2);
		repeat (2) @(posedge clock_i);
		#1;
		check("regain", {ack_b, brq_b, pins.chip_select_oe, pins.other_oe}, 8'hf);
		@(posedge clock_i);
		req.start <= 1'b0;
		wait_for(1'b1, 20, k);
		check("own_cycle", done, 8'h1);
		$display("test hold done");
	endtask
	task automatic t_hold_mid();
		int k;
		logic early;
		logic c;
		@(posedge clock_i);
		lag <= 4'h6;
		req <= '{1'b1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0};
		@(posedge clock_i);
		req.start <= 1'b0;
		hold_b <= 1'b0;
		early = 1'b0;
		for (k = 0; k < 30 && done !== 1'b1; k++) begin
			@(posedge clock_i);
			#1;
			early = early | (ack_b === 1'b0 && done !== 1'b1);
		end
		check("ack_early", {done, early}, 8'h2);
		wait_for(1'b0, 4, k);
		@(posedge clock_i);
		hold_b <= 1'b1;
		repeat (4) @(posedge clock_i);
		#1;
		c = clk_out;
		@(posedge clock_i);
		#1;
		// Clock output must change at every clock edge
		check("clk_out", clk_out, {7'h0, ~c});
		$display("test hold in cycle done");
	endtask
	initial begin
		repeat (20) @(posedge clock_i);
		rst_b_i <= 1'b1;
		t_ready();
		t_waits();
		t_gap();
		t_hold(1'b1);
		t_hold(1'b0);
		t_hold_mid();
		print_verdict();
	end
endmodule
